// [inc/isr_pkg.sv]
// Package with status-reporting constants, field positions and enumerations
package isr_pkg;
    // Register width of status byte, event and enable registers
    localparam int          ISR_W         = 8;
    // Status byte bit positions
    localparam int          ISR_MAV_BIT   = 4;
    localparam int          ISR_ESB_BIT   = 5;
    localparam int          ISR_MSS_BIT   = 6;
    // Status byte bits that may ever be one, besides bit 6
    localparam logic [7:0]  ISR_STB_USED  = 8'h30;
    // Service-request enable write mask, bit 6 never stored
    localparam logic [7:0]  ISR_SRE_MASK  = 8'hBF;
    // Standard event enable accepts every bit
    localparam logic [7:0]  ISR_ESE_MASK  = 8'hFF;
    // Reset values
    localparam logic [7:0]  ISR_EVT_RST   = 8'h00;
    localparam logic [7:0]  ISR_ENA_RST   = 8'h00;
    localparam logic [7:0]  ISR_RSP_RST   = 8'h00;
    localparam logic [7:0]  ISR_ZERO      = 8'h00;

    // Query that produced the pending answer
    typedef enum {
        ISR_Q_NONE,
        ISR_Q_ESR,
        ISR_Q_ESE,
        ISR_Q_SRE,
        ISR_Q_STB,
        ISR_Q_SPOLL,
        ISR_Q_TST
    } isr_query_e;
endpackage

// [design/isr_event_reg.sv]
// Latched event register with its enable register and summary bit
`timescale 1ns/1ns
module isr_event_reg #(
    parameter int         W        = 8,
    parameter logic [7:0] ENA_MASK = 8'hFF
) (
    input  wire logic         mclk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] evt_set,
    input  wire logic         evt_clr,
    input  wire logic         ena_wr,
    input  wire logic [W-1:0] ena_wdata,
    output logic      [W-1:0] event_q,
    output logic      [W-1:0] enable_q,
    output logic              summary
);
    import isr_pkg::*;

    logic [W-1:0] event_d;

    // Bits latch and hold; a new event in the clearing cycle survives
    always_comb begin
        event_d = (evt_clr ? ISR_EVT_RST[W-1:0] : event_q) | evt_set;
    end

    // Event storage, cleared only at power-on or by an explicit clear
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            event_q <= ISR_EVT_RST[W-1:0];
        end else begin
            event_q <= event_d;
        end
    end

    // Enable storage, touched only by its own write
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            enable_q <= ISR_ENA_RST[W-1:0];
        end else if (ena_wr) begin
            enable_q <= ena_wdata & ENA_MASK[W-1:0];
        end
    end

    // Summary is the OR of enabled event bits
    assign summary = |(event_q & enable_q);
endmodule // isr_event_reg

// [design/isr_rqs_latch.sv]
// Request-service latch driven by rising master summary
`timescale 1ns/1ns
module isr_rqs_latch (
    input  wire logic mclk,
    input  wire logic rst_n,
    input  wire logic mss,
    input  wire logic spoll_rd,
    output logic      rqs_q
);
    import isr_pkg::*;

    logic mss_prev_q;

    // Previous master summary for edge detection
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mss_prev_q <= 1'b0;
        end else begin
            mss_prev_q <= mss;
        end
    end

    // Set on a new request, cleared by a serial poll; set wins
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rqs_q <= 1'b0;
        end else if (mss && !mss_prev_q) begin
            rqs_q <= 1'b1;
        end else if (spoll_rd) begin
            rqs_q <= 1'b0;
        end
    end
endmodule // isr_rqs_latch

// [design/isr_status_top.sv]
// Status byte, standard event group, service request and query answers
`timescale 1ns/1ns
module isr_status_top (
    input  wire logic                      mclk,
    input  wire logic                      rst_n,
    input  wire logic [isr_pkg::ISR_W-1:0] std_evt,
    input  wire logic                      oq_not_empty,
    input  wire logic                      oq_rd_req,
    input  wire logic                      cmd_cls,
    input  wire logic                      cmd_rst,
    input  wire logic                      cmd_dcl,
    input  wire logic                      cmd_ese_wr,
    input  wire logic                      cmd_sre_wr,
    input  wire logic [isr_pkg::ISR_W-1:0] cmd_data,
    input  wire logic                      q_esr,
    input  wire logic                      q_ese,
    input  wire logic                      q_sre,
    input  wire logic                      q_stb,
    input  wire logic                      q_tst,
    input  wire logic                      spoll_rd,
    input  wire logic [isr_pkg::ISR_W-1:0] tst_code,
    output logic                           resp_valid,
    output logic      [isr_pkg::ISR_W-1:0] resp_data,
    output logic      [isr_pkg::ISR_W-1:0] status_byte,
    output logic                           srq,
    output logic                           hold_off
);
    import isr_pkg::*;

    logic [ISR_W-1:0] evt_q;
    logic [ISR_W-1:0] ese_q;
    logic             esb;
    logic [ISR_W-1:0] sre_q;
    logic [ISR_W-1:0] stb_base;
    logic [ISR_W-1:0] stb_mss;
    logic [ISR_W-1:0] stb_poll;
    logic             mss;
    logic             rqs_q;
    logic             esr_clr;
    isr_query_e       query_sel;
    logic [ISR_W-1:0] resp_d;
    logic             resp_valid_q;
    logic [ISR_W-1:0] resp_data_q;
    logic [ISR_W-1:0] status_byte_q;
    logic             hold_off_q;

    // Standard event register empties on its query or clear-status only
    assign esr_clr = q_esr | cmd_cls;

    // Standard event register with its enable register
    isr_event_reg #(
        .W        (ISR_W),
        .ENA_MASK (ISR_ESE_MASK)
    ) u_std_evt (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .evt_set   (std_evt),
        .evt_clr   (esr_clr),
        .ena_wr    (cmd_ese_wr),
        .ena_wdata (cmd_data),
        .event_q   (evt_q),
        .enable_q  (ese_q),
        .summary   (esb)
    );

    // Service-request enable, bit 6 masked on write
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sre_q <= ISR_ENA_RST;
        end else if (cmd_sre_wr) begin
            sre_q <= cmd_data & ISR_SRE_MASK;
        end
    end

    // Unlatched status byte built from live sources
    always_comb begin
        stb_base              = ISR_ZERO;
        stb_base[ISR_MAV_BIT] = oq_not_empty;
        stb_base[ISR_ESB_BIT] = esb;
    end

    // Master summary from enabled status byte bits, bit 6 excluded
    assign mss = |(stb_base & sre_q & ISR_SRE_MASK);

    // Status byte views for the status query and for a serial poll
    always_comb begin
        stb_mss               = stb_base;
        stb_mss[ISR_MSS_BIT]  = mss;
        stb_poll              = stb_base;
        stb_poll[ISR_MSS_BIT] = rqs_q;
    end

    // Request-service flag, cleared only by a serial poll
    isr_rqs_latch u_rqs (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .mss      (mss),
        .spoll_rd (spoll_rd),
        .rqs_q    (rqs_q)
    );

    // Fixed priority among queries arriving together
    always_comb begin
        if (q_esr) begin
            query_sel = ISR_Q_ESR;
        end else if (q_ese) begin
            query_sel = ISR_Q_ESE;
        end else if (q_sre) begin
            query_sel = ISR_Q_SRE;
        end else if (q_stb) begin
            query_sel = ISR_Q_STB;
        end else if (spoll_rd) begin
            query_sel = ISR_Q_SPOLL;
        end else if (q_tst) begin
            query_sel = ISR_Q_TST;
        end else begin
            query_sel = ISR_Q_NONE;
        end
    end

    // Answer value; binary value equals the weighted decimal sum
    always_comb begin
        case (query_sel)
            ISR_Q_ESR:   resp_d = evt_q;
            ISR_Q_ESE:   resp_d = ese_q;
            ISR_Q_SRE:   resp_d = sre_q;
            ISR_Q_STB:   resp_d = stb_mss;
            ISR_Q_SPOLL: resp_d = stb_poll;
            ISR_Q_TST:   resp_d = tst_code;
            default:     resp_d = ISR_RSP_RST;
        endcase
    end

    // Answer register: one-cycle pulse, dropped by device clear or reset
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            resp_valid_q <= 1'b0;
            resp_data_q  <= ISR_RSP_RST;
        end else if (cmd_dcl || cmd_rst) begin
            resp_valid_q <= 1'b0;
            resp_data_q  <= ISR_RSP_RST;
        end else begin
            resp_valid_q <= (query_sel != ISR_Q_NONE);
            resp_data_q  <= resp_d;
        end
    end

    // Registered copy of the status byte with master summary in bit 6
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            status_byte_q <= ISR_ZERO;
        end else begin
            status_byte_q <= stb_mss;
        end
    end

    // Bus hold-off while the controller reads an empty queue
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            hold_off_q <= 1'b0;
        end else begin
            hold_off_q <= oq_rd_req && !oq_not_empty && !cmd_dcl;
        end
    end

    assign resp_valid  = resp_valid_q;
    assign resp_data   = resp_data_q;
    assign status_byte = status_byte_q;
    assign srq         = rqs_q;
    assign hold_off    = hold_off_q;

    // Checks on the status group
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    // An event register query with no reset command or device clear beside it
    sequence esr_query_s;
        q_esr && !cmd_dcl && !cmd_rst;
    endsequence

    // A status byte query with no event, event enable or service enable query, reset command or device clear beside it
    sequence stb_query_s;
        q_stb && !q_esr && !q_ese && !q_sre && !cmd_dcl && !cmd_rst;
    endsequence

    // A quiet cycle for the event register
    sequence evt_quiet_s;
        !esr_clr && (std_evt == ISR_ZERO);
    endsequence

    // An enabled standard event arriving while the enable register stands
    sequence evt_enabled_s;
        (|(std_evt & ese_q)) && !cmd_ese_wr;
    endsequence

    latch_hold_a: assert property (
        (evt_q != ISR_ZERO) && !esr_clr |=> ((evt_q & $past(evt_q)) == $past(evt_q)))
        else $error("latched event bit was lost");

    esr_clear_a: assert property (
        esr_clr && (std_evt == ISR_ZERO) |=> (evt_q == ISR_ZERO) ##1 (evt_q == $past(std_evt)))
        else $error("event register not cleared");

    rst_keep_a: assert property (
        ((cmd_rst || cmd_dcl) and evt_quiet_s) |=> (evt_q == $past(evt_q)))
        else $error("reset or device clear altered events");

    esr_value_a: assert property (
        esr_query_s |=> resp_valid && (resp_data == $past(evt_q)))
        else $error("event query answer wrong");

    esb_sum_a: assert property (
        status_byte[ISR_ESB_BIT] == $past(|(evt_q & ese_q)))
        else $error("event summary bit wrong");

    ena_keep_a: assert property (
        (cmd_cls || q_ese) && !cmd_ese_wr |=> (ese_q == $past(ese_q)))
        else $error("enable register changed without write");

    mav_track_a: assert property (
        status_byte[ISR_MAV_BIT] == $past(oq_not_empty))
        else $error("message available bit wrong");

    unused_zero_a: assert property (
        (status_byte & ~(ISR_STB_USED | (ISR_W'(1) << ISR_MSS_BIT))) == ISR_ZERO)
        else $error("unused status byte bit set");

    clr_summary_a: assert property (
        esr_clr && (std_evt == ISR_ZERO) |=> ##1 !status_byte[ISR_ESB_BIT])
        else $error("summary survived event clear");

    mss_calc_a: assert property (
        status_byte[ISR_MSS_BIT] == $past(|(stb_base & sre_q)))
        else $error("master summary wrong");

    poll_rqs_a: assert property (
        spoll_rd && !q_esr && !q_ese && !q_sre && !q_stb && !cmd_dcl && !cmd_rst
        |=> resp_valid && (resp_data[ISR_MSS_BIT] == $past(rqs_q)))
        else $error("serial poll bit 6 wrong");

    stb_query_a: assert property (
        stb_query_s |=> resp_valid && (resp_data == $past(stb_mss)))
        else $error("status query answer wrong");

    stb_norqs_a: assert property (
        (stb_query_s and (!spoll_rd && rqs_q)) |=> rqs_q)
        else $error("status query cleared request flag");

    hold_wait_a: assert property (
        oq_rd_req && !oq_not_empty && !cmd_dcl |=> hold_off ##0 !(hold_off && oq_not_empty && $past(oq_not_empty)))
        else $error("hold-off not raised on empty read");

    hold_release_a: assert property (
        oq_not_empty |=> !hold_off)
        else $error("hold-off while queue holds data");

    tst_value_a: assert property (
        q_tst && !q_esr && !q_ese && !q_sre && !q_stb && !spoll_rd && !cmd_dcl && !cmd_rst
        |=> resp_valid && (resp_data == $past(tst_code)))
        else $error("self-test answer wrong");

    sre_bit6_a: assert property (
        cmd_sre_wr |=> !sre_q[ISR_MSS_BIT] && (sre_q == ($past(cmd_data) & ISR_SRE_MASK)))
        else $error("service enable bit 6 stored");

    rqs_set_a: assert property (
        $rose(mss) |=> srq)
        else $error("request flag not set on new summary");

    resp_pulse_a: assert property (
        (query_sel == ISR_Q_NONE) || cmd_dcl || cmd_rst |=> !resp_valid)
        else $error("answer without query");

    // Enable registers, event register, status byte bits, request flag and hold-off
    ena_read_a: assert property (
        q_ese && !q_esr && !cmd_dcl && !cmd_rst |=> resp_valid && (resp_data == $past(ese_q)))
        else $error("enable query answer wrong");

    ese_write_a: assert property (
        cmd_ese_wr |=> (ese_q == $past(cmd_data)))
        else $error("event enable write lost");

    sre_keep_a: assert property (
        (cmd_cls || q_sre) && !cmd_sre_wr |=> (sre_q == $past(sre_q)))
        else $error("service enable changed without write");

    sre_read_a: assert property (
        q_sre && !q_esr && !q_ese && !cmd_dcl && !cmd_rst
        |=> resp_valid && !resp_data[ISR_MSS_BIT] && (resp_data == $past(sre_q)))
        else $error("service enable query answer wrong");

    mav_drop_a: assert property (
        !oq_not_empty |=> !status_byte[ISR_MAV_BIT])
        else $error("message available bit latched");

    esb_pending_a: assert property (
        evt_enabled_s |=> ##1 status_byte[ISR_ESB_BIT])
        else $error("enabled event not summarised");

    evt_noset_a: assert property (
        (evt_q == ISR_ZERO) && (std_evt == ISR_ZERO) |=> (evt_q == ISR_ZERO))
        else $error("event bit set without condition");

    cls_clear_a: assert property (
        cmd_cls |=> (evt_q == $past(std_evt)))
        else $error("clear-status left event bits");

    rqs_hold_a: assert property (
        srq && !spoll_rd |=> srq)
        else $error("request flag dropped without poll");

    poll_clear_a: assert property (
        spoll_rd && !$rose(mss) |=> !srq)
        else $error("serial poll left request flag");

    hold_dcl_a: assert property (
        cmd_dcl |=> !hold_off)
        else $error("hold-off kept through device clear");

    mss_off_a: assert property (
        (sre_q == ISR_ZERO) |=> !status_byte[ISR_MSS_BIT])
        else $error("master summary without enable");
endmodule // isr_status_top

// [testbench/isr_ctrl_model.sv]
// Remote controller model issuing common commands and queries one at a time
`timescale 1ns/1ns
module isr_ctrl_model (
    input  wire logic                      mclk,
    input  wire logic                      resp_valid,
    input  wire logic [isr_pkg::ISR_W-1:0] resp_data,
    output logic                           cmd_cls,
    output logic                           cmd_rst,
    output logic                           cmd_dcl,
    output logic                           cmd_ese_wr,
    output logic                           cmd_sre_wr,
    output logic      [isr_pkg::ISR_W-1:0] cmd_data,
    output logic                           q_esr,
    output logic                           q_ese,
    output logic                           q_sre,
    output logic                           q_stb,
    output logic                           spoll_rd,
    output logic                           q_tst
);
    import isr_pkg::*;
    logic [10:0] strb_q;

    // One strobe line per operation, index order is the op code
    assign {q_tst, spoll_rd, q_stb, q_sre, q_ese, q_esr} = strb_q[10:5];
    assign {cmd_sre_wr, cmd_ese_wr, cmd_dcl, cmd_rst, cmd_cls} = strb_q[4:0];

    initial begin
        strb_q   = 11'h000;
        cmd_data = 8'h00;
    end

    // One-cycle strobe, answer taken 1 ns after the edge that takes the strobe
    task automatic xfer(input int op, input logic [7:0] d, output logic got, output logic [7:0] rd);
        @(posedge mclk);
        #1;
        strb_q   = 11'h001 << op;
        cmd_data = d;
        @(posedge mclk);
        #1;
        got      = resp_valid;
        rd       = resp_data;
        strb_q   = 11'h000;
        cmd_data = ~d; // Data no longer qualified, never left at last value
    endtask
endmodule // isr_ctrl_model

// [testbench/instrument_status_reporting_bench.sv]
// Self-checking bench for the status-reporting block
`timescale 1ns/1ns
module instrument_status_reporting_bench;
    import isr_pkg::*;
    logic       mclk, rst_n, oq_not_empty, oq_rd_req;
    logic       cmd_cls, cmd_rst, cmd_dcl, cmd_ese_wr, cmd_sre_wr;
    logic       q_esr, q_ese, q_sre, q_stb, q_tst, spoll_rd;
    logic       resp_valid, srq, hold_off;
    logic [7:0] std_evt, cmd_data, tst_code, resp_data, status_byte;
    int         bad_count, num_checks, cyc;
    logic [7:0] row_ese [4] = '{8'hFF, 8'h01, 8'h80, 8'h3C};
    logic [7:0] row_evt [4] = '{8'h01, 8'h02, 8'h80, 8'hC3};
    logic [7:0] row_stb [4] = '{8'h20, 8'h00, 8'h20, 8'h00};

    isr_status_top dut_u (.mclk(mclk), .rst_n(rst_n), .std_evt(std_evt), .oq_not_empty(oq_not_empty),
        .oq_rd_req(oq_rd_req), .cmd_cls(cmd_cls), .cmd_rst(cmd_rst), .cmd_dcl(cmd_dcl),
        .cmd_ese_wr(cmd_ese_wr), .cmd_sre_wr(cmd_sre_wr), .cmd_data(cmd_data), .q_esr(q_esr),
        .q_ese(q_ese), .q_sre(q_sre), .q_stb(q_stb), .q_tst(q_tst), .spoll_rd(spoll_rd),
        .tst_code(tst_code), .resp_valid(resp_valid), .resp_data(resp_data),
        .status_byte(status_byte), .srq(srq), .hold_off(hold_off));

    isr_ctrl_model model_u (.mclk(mclk), .resp_valid(resp_valid), .resp_data(resp_data),
        .cmd_cls(cmd_cls), .cmd_rst(cmd_rst), .cmd_dcl(cmd_dcl), .cmd_ese_wr(cmd_ese_wr),
        .cmd_sre_wr(cmd_sre_wr), .cmd_data(cmd_data), .q_esr(q_esr), .q_ese(q_ese), .q_sre(q_sre),
        .q_stb(q_stb), .spoll_rd(spoll_rd), .q_tst(q_tst));

    // 25 MHz clock
    initial mclk = 1'b0;
    always #20 mclk = ~mclk;

    // Cycle ceiling against a hung run
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            $display("[FAIL] %0t timeout", $time);
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("checks=%0d mismatches=%0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    // Query: answer must come one cycle later with the expected byte
    task automatic query(input int op, input logic [7:0] exp);
        logic       v;
        logic [7:0] r;
        model_u.xfer(op, 8'h00, v, r);
        chk({7'h00, v}, 8'h01, "answer valid");
        chk(r, exp, "answer data");
    endtask

    // Command: no answer expected
    task automatic cmd(input int op, input logic [7:0] d);
        logic       v;
        logic [7:0] r;
        model_u.xfer(op, d, v, r);
        chk({7'h00, v}, 8'h00, "command answered");
    endtask

    task automatic pulse_evt(input logic [7:0] e);
        @(posedge mclk);
        #1 std_evt = e;
        @(posedge mclk);
        #1 std_evt = 8'h00;
    endtask

    task automatic settle();
        repeat (4) @(posedge mclk);
        #1;
    endtask

    initial begin
        rst_n = 1'b0; std_evt = 8'h00; oq_not_empty = 1'b0; oq_rd_req = 1'b0; tst_code = 8'h00;
        repeat (8) @(posedge mclk);
        #1 rst_n = 1'b1;
        chk(status_byte, 8'h00, "reset status");
        chk({5'h00, srq, hold_off, resp_valid}, 8'h00, "reset flags");
        // Table of enable, event and the status byte they give
        for (int i = 0; i < 4; i++) begin
            cmd(3, row_ese[i]);
            pulse_evt(row_evt[i]);
            settle();
            chk(status_byte, row_stb[i], "summary bit");
            query(6, row_ese[i]);
            query(5, row_evt[i]);
            query(5, 8'h00);
            settle();
            chk(status_byte, 8'h00, "summary cleared");
        end
        // Latching, reset command and device clear keep events
        cmd(3, 8'h04);
        pulse_evt(8'h04);
        pulse_evt(8'h10);
        cmd(1, 8'h00);
        cmd(2, 8'h00);
        query(5, 8'h14);
        pulse_evt(8'h04);
        cmd(0, 8'h00);
        query(5, 8'h00);
        query(6, 8'h04);
        // Power-on clears events
        pulse_evt(8'hFF);
        #1 rst_n = 1'b0;
        repeat (2) @(posedge mclk);
        #1 rst_n = 1'b1;
        query(5, 8'h00);
        // Message-available follows the queue one cycle behind
        @(posedge mclk);
        #1 oq_not_empty = 1'b1;
        @(posedge mclk);
        #1 chk(status_byte, 8'h10, "mav set");
        oq_not_empty = 1'b0;
        @(posedge mclk);
        #1 chk(status_byte, 8'h00, "mav unlatched");
        // Service request enable, master summary and serial poll
        cmd(4, 8'hFF);
        query(7, 8'hBF);
        cmd(4, 8'h10);
        oq_not_empty = 1'b1;
        settle();
        chk(status_byte, 8'h50, "master summary");
        chk({7'h00, srq}, 8'h01, "request set");
        query(8, 8'h50);
        chk({7'h00, srq}, 8'h01, "status query kept request");
        query(9, 8'h50);
        settle();
        chk({7'h00, srq}, 8'h00, "poll cleared request");
        query(9, 8'h10);
        query(8, 8'h50);
        oq_not_empty = 1'b0;
        settle();
        chk(status_byte, 8'h00, "summary gone");
        // Self-test result
        query(10, 8'h00);
        tst_code = 8'h5A;
        query(10, 8'h5A);
        // Early queue read is held off until data is there
        @(posedge mclk);
        #1 oq_rd_req = 1'b1;
        @(posedge mclk);
        #1 chk({7'h00, hold_off}, 8'h01, "hold off");
        cmd(2, 8'h00);
        chk({7'h00, hold_off}, 8'h00, "device clear drops hold");
        @(posedge mclk);
        #1 chk({7'h00, hold_off}, 8'h01, "hold off again");
        oq_not_empty = 1'b1;
        @(posedge mclk);
        #1 chk({7'h00, hold_off}, 8'h00, "hold released");
        oq_rd_req = 1'b0;
        oq_not_empty = 1'b0;
        end_of_test();
    end
endmodule // instrument_status_reporting_bench
